// ===== core/tcu_defines.vh
`ifndef TCU_DEFINES_VH
`define TCU_DEFINES_VH
// Register indices
`define TCU_IDX_INTCTL   8'h0b
`define TCU_IDX_PFLAGS   8'h0c
`define TCU_IDX_TMRL     8'h0e
`define TCU_IDX_TMRH     8'h0f
`define TCU_IDX_TCFG     8'h10
`define TCU_IDX_CMPL     8'h15
`define TCU_IDX_CMPH     8'h16
`define TCU_IDX_MCTL     8'h17
`define TCU_IDX_PDIR     8'h87
`define TCU_IDX_PEN      8'h8c
`define TCU_IDX_IRQST    8'h90
`define TCU_IDX_IRQMSK   8'h91
// Reset values
`define TCU_RST_PDIR     8'hff
`define TCU_RST_ZERO     8'h00
// Field positions
`define TCU_BIT_TOVF     0
`define TCU_BIT_MATCH    2
`define TCU_BIT_ADIF     6
`define TCU_BIT_GIE      7
`define TCU_BIT_PERIPHERAL_IRQ_ENABLE     6
`define TCU_BIT_TON      0
`define TCU_BIT_TSRC     1
`define TCU_BIT_TSYNC_N  2
`define TCU_BIT_PIN      2
`define TCU_PFLAG_MASK   8'h47
// Compare modes
`define TCU_MODE_SET     4'h8
`define TCU_MODE_CLR     4'h9
`define TCU_MODE_SWI     4'ha
`define TCU_MODE_SPEC    4'hb
// Event bits of the sticky status
`define TCU_EV_MATCH     0
`define TCU_EV_TOVF      1
`define TCU_EV_SPEC      2
`define TCU_EV_MASK      8'h07
// AXI responses
`define TCU_RESP_OKAY    2'b00
`define TCU_RESP_SLVERR  2'b10
`endif

// ===== core/tcu_timer.v
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tcu_timer #(
    parameter WIDTH = 16
) (
    aclk,
    aresetn,
    ce,
    tick,
    wr_lo,
    wr_hi,
    wdata,
    clr,
    count,
    ovf
);
    input              aclk;
    input              aresetn;
    input              ce;
    input              tick;
    input              wr_lo;
    input              wr_hi;
    input  [7:0]       wdata;
    input              clr;
    output [WIDTH-1:0] count;
    output             ovf;

    reg  [WIDTH-1:0] count_r;
    reg  [WIDTH-1:0] count_nxt;
    reg              ovf_nxt;

    assign count = count_r;
    assign ovf   = ovf_nxt;

    always @*
    begin
        count_nxt = count_r;
        ovf_nxt   = 1'b0;
        if (clr)
            count_nxt = {WIDTH{1'b0}};
        else if (wr_lo)
            count_nxt = {count_r[WIDTH-1:8], wdata};
        else if (wr_hi)
            count_nxt = {wdata, count_r[7:0]};
        else if (tick)
        begin
            count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            ovf_nxt   = &count_r;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            count_r <= {WIDTH{1'b0}};
        else if (ce)
            count_r <= count_nxt;
    end
endmodule

// ===== core/tcu_top.v
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tcu_top (
    aclk,
    aresetn,
    ce,
    ext_clk_pin,
    adc_enable,
    adc_start,
    cmp_pin_o,
    cmp_pin_oe_n,
    periph_irq,
    irq,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input         aclk;
    input         aresetn;
    input         ce;
    input         ext_clk_pin;
    input         adc_enable;
    output        adc_start;
    output        cmp_pin_o;
    output        cmp_pin_oe_n;
    output        periph_irq;
    output        irq;
    input  [11:0] s_axi_awaddr;
    input         s_axi_awvalid;
    output        s_axi_awready;
    input  [31:0] s_axi_wdata;
    input  [3:0]  s_axi_wstrb;
    input         s_axi_wvalid;
    output        s_axi_wready;
    output [1:0]  s_axi_bresp;
    output        s_axi_bvalid;
    input         s_axi_bready;
    input  [11:0] s_axi_araddr;
    input         s_axi_arvalid;
    output        s_axi_arready;
    output [31:0] s_axi_rdata;
    output [1:0]  s_axi_rresp;
    output        s_axi_rvalid;
    input         s_axi_rready;

    // ************************************************************
    // Helpers
    // ************************************************************
    function known_idx;
        input [9:0] idx;
        begin
            case (idx[7:0])
                `TCU_IDX_INTCTL, `TCU_IDX_PFLAGS, `TCU_IDX_TMRL, `TCU_IDX_TMRH,
                `TCU_IDX_TCFG, `TCU_IDX_CMPL, `TCU_IDX_CMPH, `TCU_IDX_MCTL,
                `TCU_IDX_PDIR, `TCU_IDX_PEN, `TCU_IDX_IRQST, `TCU_IDX_IRQMSK:
                    known_idx = (idx[9:8] == 2'b00);
                default:
                    known_idx = 1'b0;
            endcase
        end
    endfunction

    // ************************************************************
    // Registers and pin sync
    // ************************************************************
    reg  [7:0]  intctl_r;
    reg  [7:0]  pflags_r;
    reg  [7:0]  tcfg_r;
    reg  [15:0] cmp_r;
    reg  [7:0]  mctl_r;
    reg  [7:0]  pdir_r;
    reg  [7:0]  pen_r;
    reg  [7:0]  irqst_r;
    reg  [7:0]  irqmsk_r;
    reg         pin_latch_r;
    reg         adc_start_r;
    reg         ext_s1_r;
    reg         ext_s2_r;
    reg         ext_prev_r;

    reg         aw_full_r;
    reg  [9:0]  aw_idx_r;
    reg         w_full_r;
    reg  [7:0]  w_data_r;
    reg         w_strb_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;
    reg         rvalid_r;
    reg  [31:0] rdata_r;
    reg  [1:0]  rresp_r;

    wire [15:0] count;
    wire        tovf;
    wire        do_wr  = aw_full_r && w_full_r && !bvalid_r;
    wire        wr_ok  = do_wr && w_strb_r && known_idx(aw_idx_r);
    wire [7:0]  widx   = aw_idx_r[7:0];
    wire        wr_tl  = wr_ok && widx == `TCU_IDX_TMRL;
    wire        wr_th  = wr_ok && widx == `TCU_IDX_TMRH;

    wire        t_on   = tcfg_r[`TCU_BIT_TON];
    wire        t_ext  = tcfg_r[`TCU_BIT_TSRC];
    wire        ext_rise = ext_s2_r && !ext_prev_r;
    wire        tick   = t_on && (t_ext ? ext_rise : 1'b1);

    // ************************************************************
    // Compare logic
    // ************************************************************
    wire [3:0]  mode   = mctl_r[3:0];
    wire        cmp_mode = (mode == `TCU_MODE_SET) || (mode == `TCU_MODE_CLR) ||
                           (mode == `TCU_MODE_SWI) || (mode == `TCU_MODE_SPEC);
    wire        match  = cmp_mode && (count == cmp_r);
    wire        spec   = match && (mode == `TCU_MODE_SPEC);

    tcu_timer #(
        .WIDTH (16)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tick    (tick),
        .wr_lo   (wr_tl),
        .wr_hi   (wr_th),
        .wdata   (w_data_r),
        .clr     (spec),
        .count   (count),
        .ovf     (tovf)
    );

    // ************************************************************
    // Register file and events
    // ************************************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            intctl_r    <= `TCU_RST_ZERO;
            pflags_r    <= `TCU_RST_ZERO;
            tcfg_r      <= `TCU_RST_ZERO;
            cmp_r       <= {`TCU_RST_ZERO, `TCU_RST_ZERO};
            mctl_r      <= `TCU_RST_ZERO;
            pdir_r      <= `TCU_RST_PDIR;
            pen_r       <= `TCU_RST_ZERO;
            irqst_r     <= `TCU_RST_ZERO;
            irqmsk_r    <= `TCU_RST_ZERO;
            pin_latch_r <= 1'b0;
            adc_start_r <= 1'b0;
            ext_s1_r    <= 1'b0;
            ext_s2_r    <= 1'b0;
            ext_prev_r  <= 1'b0;
        end
        else if (ce)
        begin
            ext_s1_r    <= ext_clk_pin;
            ext_s2_r    <= ext_s1_r;
            ext_prev_r  <= ext_s2_r;
            adc_start_r <= spec && adc_enable;
            if (wr_ok)
            begin
                case (widx)
                    `TCU_IDX_INTCTL: intctl_r <= w_data_r;
                    `TCU_IDX_PFLAGS: pflags_r <= w_data_r & `TCU_PFLAG_MASK;
                    `TCU_IDX_TCFG:   tcfg_r   <= {2'b00, w_data_r[5:0]};
                    `TCU_IDX_CMPL:   cmp_r[7:0]  <= w_data_r;
                    `TCU_IDX_CMPH:   cmp_r[15:8] <= w_data_r;
                    `TCU_IDX_MCTL:   mctl_r   <= {2'b00, w_data_r[5:0]};
                    `TCU_IDX_PDIR:   pdir_r   <= w_data_r;
                    `TCU_IDX_PEN:    pen_r    <= w_data_r & `TCU_PFLAG_MASK;
                    `TCU_IDX_IRQST:  irqst_r  <= irqst_r & ~w_data_r;
                    `TCU_IDX_IRQMSK: irqmsk_r <= w_data_r & `TCU_EV_MASK;
                    default:         intctl_r <= intctl_r;
                endcase
            end
            if (wr_ok && widx == `TCU_IDX_MCTL && w_data_r == `TCU_RST_ZERO)
                pin_latch_r <= 1'b0;
            else if (match && mode == `TCU_MODE_SET)
                pin_latch_r <= 1'b1;
            else if (match && mode == `TCU_MODE_CLR)
                pin_latch_r <= 1'b0;
            // Hardware sets win over software writes
            if (match)
                pflags_r[`TCU_BIT_MATCH] <= 1'b1;
            if (tovf && !spec)
                pflags_r[`TCU_BIT_TOVF] <= 1'b1;
            if (match)
                irqst_r[`TCU_EV_MATCH] <= 1'b1;
            if (tovf && !spec)
                irqst_r[`TCU_EV_TOVF] <= 1'b1;
            if (spec)
                irqst_r[`TCU_EV_SPEC] <= 1'b1;
        end
    end

    assign cmp_pin_o    = pin_latch_r;
    assign cmp_pin_oe_n = pdir_r[`TCU_BIT_PIN];
    assign adc_start    = adc_start_r;
    assign periph_irq   = intctl_r[`TCU_BIT_GIE] && intctl_r[`TCU_BIT_PERIPHERAL_IRQ_ENABLE] &&
                          |(pflags_r & pen_r);
    assign irq          = |(irqst_r & irqmsk_r);

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    reg [7:0] rd_byte;
    always @*
    begin
        rd_byte = 8'h00;
        case (s_axi_araddr[9:2])
            `TCU_IDX_INTCTL: rd_byte = intctl_r;
            `TCU_IDX_PFLAGS: rd_byte = pflags_r;
            `TCU_IDX_TMRL:   rd_byte = count[7:0];
            `TCU_IDX_TMRH:   rd_byte = count[15:8];
            `TCU_IDX_TCFG:   rd_byte = tcfg_r;
            `TCU_IDX_CMPL:   rd_byte = cmp_r[7:0];
            `TCU_IDX_CMPH:   rd_byte = cmp_r[15:8];
            `TCU_IDX_MCTL:   rd_byte = mctl_r;
            `TCU_IDX_PDIR:   rd_byte = pdir_r;
            `TCU_IDX_PEN:    rd_byte = pen_r;
            `TCU_IDX_IRQST:  rd_byte = irqst_r;
            `TCU_IDX_IRQMSK: rd_byte = irqmsk_r;
            default:         rd_byte = 8'h00;
        endcase
    end

    assign s_axi_awready = !aw_full_r && ce;
    assign s_axi_wready  = !w_full_r && ce;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r && ce;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            aw_idx_r  <= 10'h000;
            w_full_r  <= 1'b0;
            w_data_r  <= 8'h00;
            w_strb_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `TCU_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `TCU_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && !aw_full_r)
            begin
                aw_full_r <= 1'b1;
                aw_idx_r  <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && !w_full_r)
            begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= known_idx(aw_idx_r) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
            if (s_axi_arvalid && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r  <= known_idx(s_axi_araddr[11:2]) ? {24'h000000, rd_byte} : 32'h00000000;
                rresp_r  <= known_idx(s_axi_araddr[11:2]) ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end
endmodule

// ===== tb/tcu_chk.sv
`timescale 1ns/1ps
module tcu_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        adc_enable,
    input wire        adc_start,
    input wire        cmp_pin_o,
    input wire        cmp_pin_oe_n,
    input wire        irq,
    input wire        periph_irq,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    reg [9:0] aw_r;
    reg [9:0] ar_r;
    reg [7:0] wd_r;
    reg       ws_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    function automatic logic mapped(input [9:0] i);
        mapped = i == 10'h0b || i == 10'h0c || i == 10'h0e || i == 10'h0f || i == 10'h10 || i == 10'h15
            || i == 10'h16 || i == 10'h17 || i == 10'h87 || i == 10'h8c || i == 10'h90 || i == 10'h91;
    endfunction
    always @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr[11:2];
        if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr[11:2];
        if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[0];
    end
    chk_rst_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
        && cmp_pin_oe_n && !cmp_pin_o) else $error("outputs not idle after reset");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_r_unmap: assert property ($rose(s_axi_rvalid) && !mapped(ar_r) |-> s_axi_rresp == 2'b10
        && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    chk_adc_gate: assert property (adc_start |-> $past(adc_enable)) else $error("conversion while disabled");
    chk_adc_pulse: assert property (adc_start |=> !adc_start) else $error("conversion start too long");
    chk_ctl_zero: assert property ($rose(s_axi_bvalid) && aw_r == 10'h17 && ws_r && wd_r == 8'h00 |-> ##[0:1] !cmp_pin_o)
        else $error("latch not forced low");
    chk_dir_pin: assert property ($rose(s_axi_bvalid) && aw_r == 10'h87 && ws_r |-> ##[0:1] cmp_pin_oe_n == wd_r[2])
        else $error("pin enable wrong");
    cov_adc: cover property (adc_start);
    cov_irq: cover property ($rose(irq));
    cov_pirq: cover property ($rose(periph_irq));
endmodule
bind tcu_top tcu_chk chk_u (.aclk, .aresetn, .adc_enable, .adc_start, .cmp_pin_o, .cmp_pin_oe_n, .irq, .periph_irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== tb/tcu_pin_mon.sv
`timescale 1ns/1ps
module tcu_pin_mon (
    input wire   aclk,
    input wire   pin_o,
    input wire   oe_n,
    output logic level
);
    logic last = 1'b0;
    always @(posedge aclk)
        if (!oe_n) last <= pin_o;
    // Released line shows the inverse of its last level
    assign level = oe_n ? ~last : pin_o;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "tcu_defines.vh"
module tb_top;
    logic        aclk = 0, aresetn = 0, adc_en = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, seed = 32'haa363e45;
    logic [3:0]  wstrb = 0;
    logic [1:0]  resp;
    logic [7:0]  d;
    logic [15:0] cv, fix_cv = 16'h0;
    logic        exp_pin = 0, ce = 1;
    logic [7:0]  ri [8] = '{8'h0b, 8'h0c, 8'h10, 8'h17, 8'h87, 8'h8c, 8'h0e, 8'h15};
    logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    wire         awready, wready, bvalid, arready, rvalid, adc_start, pin_o, oe_n, pirq, irq, level;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    integer      n_fail = 0, n_checks = 0, adc_cnt = 0, adc_base = 0, k, j;
    tcu_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .ext_clk_pin(1'b0), .adc_enable(adc_en),
        .adc_start(adc_start), .cmp_pin_o(pin_o), .cmp_pin_oe_n(oe_n), .periph_irq(pirq), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    tcu_pin_mon pm_u (.aclk(aclk), .pin_o(pin_o), .oe_n(oe_n), .level(level));
    initial
        forever #4 aclk = ~aclk;
    always @(posedge aclk)
        if (adc_start) adc_cnt <= adc_cnt + 1;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function pin_f(input [3:0] m, input p);
        pin_f = m == `TCU_MODE_SET ? 1'b1 : m == `TCU_MODE_CLR ? 1'b0 : p;
    endfunction
    task close_out;
        begin
            $display("checks %0d fails %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk8(input [7:0] g, input [7:0] e);
        begin
            n_checks++;
            if (g !== e)
            begin
                n_fail++;
                $display("[ERR] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task tmo(input integer n);
        begin
            if (n >= 100) n_fail++;
            if (n >= 100) close_out;
        end
    endtask
    task wr(input [7:0] i, input [7:0] v);
        begin
            @(posedge aclk);
            awaddr <= {2'b00, i, 2'b00};
            wdata <= {24'h0, v};
            wstrb <= 4'h1;
            awv <= 1;
            wv <= 1;
            bready <= 1;
            for (k = 0; k < 100; k++)
            begin
                @(posedge aclk);
                if (awready) awv <= 0;
                if (wready) wv <= 0;
                if (bvalid) break;
            end
            resp = bresp;
            bready <= 0;
            tmo(k);
        end
    endtask
    task rd(input [7:0] i);
        begin
            @(posedge aclk);
            araddr <= {2'b00, i, 2'b00};
            arv <= 1;
            rready <= 1;
            for (k = 0; k < 100; k++)
            begin
                @(posedge aclk);
                if (arready) arv <= 0;
                if (rvalid) break;
            end
            resp = rresp;
            d = rdata[7:0];
            rready <= 0;
            tmo(k);
        end
    endtask
    task run(input [3:0] m, input a);
        begin
            seed = lfsr(seed);
            cv = {seed[15:8] | 8'h01, (seed[7:0] & 8'h7f) | 8'h10};
            if (fix_cv != 16'h0) cv = fix_cv;
            adc_en <= a;
            wr(`TCU_IDX_MCTL, {4'h0, `TCU_MODE_SWI});
            wr(`TCU_IDX_TMRL, cv[7:0] - 8'h08);
            wr(`TCU_IDX_TMRH, cv[15:8]);
            wr(`TCU_IDX_CMPL, cv[7:0]);
            wr(`TCU_IDX_CMPH, cv[15:8]);
            wr(`TCU_IDX_MCTL, {4'h0, m});
            wr(`TCU_IDX_PFLAGS, 8'h00);
            wr(`TCU_IDX_IRQST, 8'h07);
            adc_base = adc_cnt;
            wr(`TCU_IDX_TCFG, 8'h01);
            for (j = 0; j < 100 && pirq !== 1'b1; j++) @(posedge aclk);
            tmo(j);
            wr(`TCU_IDX_TCFG, 8'h00);
            exp_pin = pin_f(m, exp_pin);
            chk8({7'h0, level}, {7'h0, exp_pin});
            rd(`TCU_IDX_PFLAGS);
            chk8(d & 8'h05, 8'h04);
            rd(`TCU_IDX_IRQST);
            chk8(d, {5'h0, m == `TCU_MODE_SPEC, 2'b01});
            rd(`TCU_IDX_TMRH);
            chk8(d, m == `TCU_MODE_SPEC ? 8'h00 : cv[15:8]);
            chk8(8'(adc_cnt - adc_base), {7'h0, m == `TCU_MODE_SPEC && a});
        end
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        for (integer r = 0; r < 8; r++)
        begin
            rd(ri[r]);
            chk8(d, rv[r]);
        end
        rd(8'h20);
        chk8({resp, d[5:0]}, 8'h80);
        wr(8'h20, 8'h5a);
        chk8({6'h0, resp}, 8'h02);
        fork
            wr(`TCU_IDX_TMRL, 8'h3c);
            begin
                ce <= 0;
                repeat (30) @(posedge aclk);
                ce <= 1;
            end
        join
        chk8({7'h0, k >= 30}, 8'h01);
        rd(`TCU_IDX_TMRL);
        chk8(d, 8'h3c);
        wr(`TCU_IDX_PDIR, 8'hfb);
        chk8({7'h0, oe_n}, 8'h00);
        wr(`TCU_IDX_INTCTL, 8'hc0);
        wr(`TCU_IDX_PEN, 8'h04);
        run(`TCU_MODE_SET, 1'b0);
        run(`TCU_MODE_SWI, 1'b0);
        run(`TCU_MODE_CLR, 1'b0);
        run(`TCU_MODE_SET, 1'b0);
        wr(`TCU_IDX_MCTL, 8'h00);
        exp_pin = 0;
        chk8({7'h0, level}, 8'h00);
        run(`TCU_MODE_SPEC, 1'b1);
        run(`TCU_MODE_SPEC, 1'b0);
        fix_cv = 16'hffff;
        run(`TCU_MODE_SPEC, 1'b1);
        wr(`TCU_IDX_INTCTL, 8'h40);
        chk8({7'h0, pirq}, 8'h00);
        wr(`TCU_IDX_INTCTL, 8'hc0);
        chk8({7'h0, pirq}, 8'h01);
        chk8({7'h0, irq}, 8'h00);
        wr(`TCU_IDX_IRQMSK, 8'h01);
        chk8({7'h0, irq}, 8'h01);
        wr(`TCU_IDX_IRQST, 8'h01);
        chk8({7'h0, irq}, 8'h00);
        close_out;
    end
endmodule
